// ==== bench/frame_source.sv ====
// upstream header parser model: presents parsed fields with a valid held from put until idle
`timescale 1ns/1ps
module frame_source
(
	input wire logic sys_clk,
	output logic frame_valid,
	output acl_match_pkg::frame_fields_s frame_fields
);
	import acl_match_pkg::*;

	// quiet bus at time zero
	initial
	begin
		frame_valid = 1'h0;
		frame_fields = '0;
	end

	// present one frame at the next edge; valid stays up if put again
	task automatic put(input frame_fields_s f);
		@(posedge sys_clk);
		frame_valid <= 1'h1;
		frame_fields <= f;
	endtask : put

	// release: fields go to the inverse so stale data never looks valid
	task automatic idle();
		@(posedge sys_clk);
		frame_valid <= 1'h0;
		frame_fields <= ~frame_fields;
	endtask : idle

endmodule : frame_source

// ==== bench/ipv6_icmp_acl_entry_matcher_tb.sv ====
// self-checking bench for the entry matcher
`timescale 1ns/1ps
`include "acl_match_defines.svh"
`define CHK(a, e, m) begin samples_checked++; \
	if ((a) !== (e)) begin error_cnt++; $display("BAD %0t %s", $time, m); end end
module ipv6_icmp_acl_entry_matcher_tb;
	import acl_match_pkg::*;

	typedef struct packed
	{
		logic [7:0] ctrl;
		logic [7:0] nh;
		logic [31:0] pat;
		logic [31:0] mask;
		logic [15:0] icmp;
		frame_fields_s f;
		logic hit;
	} row_s;

	logic sys_clk = 1'h0;
	logic srst = 1'h1;
	logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic [31:0] s_axi_wdata = '0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic frame_valid, hit_valid, entry_hit;
	frame_fields_s frame_fields;
	int error_cnt = 0;
	int samples_checked = 0;

	// ordinary cases: configuration, frame, expected hit
	row_s rows [0:27] = '{
		'{8'h00, 8'h00, 32'h0, 32'h0, 16'h0, '{8'h06, 32'h1234_5678, 8'h40, 8'h01, 8'h02}, 1'h1},
		'{8'h01, 8'h2B, 32'h0, 32'h0, 16'h0, '{8'h2B, 32'h0, 8'h40, 8'h00, 8'h00}, 1'h1},
		'{8'h01, 8'h2B, 32'h0, 32'h0, 16'h0, '{8'h2C, 32'h0, 8'h40, 8'h00, 8'h00}, 1'h0},
		'{8'h01, 8'hFF, 32'h0, 32'h0, 16'h0, '{8'hFF, 32'h0, 8'h40, 8'h00, 8'h00}, 1'h1},
		'{8'h01, 8'h00, 32'h0, 32'h0, 16'h0, '{8'h00, 32'h0, 8'h40, 8'h00, 8'h00}, 1'h1},
		'{8'h02, 8'h00, 32'h0, 32'h0, 16'h0, '{8'h3A, 32'h0, 8'h40, 8'h00, 8'h00}, 1'h1},
		'{8'h02, 8'h00, 32'h0, 32'h0, 16'h0, '{8'h11, 32'h0, 8'h40, 8'h00, 8'h00}, 1'h0},
		'{8'h03, 8'h00, 32'h0, 32'h0, 16'h0, '{8'h11, 32'h0, 8'h40, 8'h00, 8'h00}, 1'h1},
		'{8'h04, 8'h00, 32'h0, 32'h0, 16'h0, '{8'h06, 32'h0, 8'h40, 8'h00, 8'h00}, 1'h1},
		'{8'h04, 8'h00, 32'h0, 32'h0, 16'h0, '{8'h3A, 32'h0, 8'h40, 8'h00, 8'h00}, 1'h0},
		'{8'h08, 8'h00, 32'h3, 32'hFFFF_FFFE, 16'h0, '{8'h06, 32'h2, 8'h40, 8'h00, 8'h00}, 1'h1},
		'{8'h08, 8'h00, 32'h3, 32'hFFFF_FFFE, 16'h0, '{8'h06, 32'h3, 8'h40, 8'h00, 8'h00}, 1'h1},
		'{8'h08, 8'h00, 32'h3, 32'hFFFF_FFFE, 16'h0, '{8'h06, 32'h1, 8'h40, 8'h00, 8'h00}, 1'h0},
		'{8'h08, 8'h00, 32'h3, 32'hFFFF_FFFF, 16'h0, '{8'h06, 32'h8000_0003, 8'h40, 8'h00, 8'h00}, 1'h0},
		'{8'h00, 8'h00, 32'h3, 32'hFFFF_FFFF, 16'h0, '{8'h06, 32'h8000_0000, 8'h40, 8'h00, 8'h00}, 1'h1},
		'{8'h10, 8'h00, 32'h0, 32'h0, 16'h0, '{8'h06, 32'h0, 8'h00, 8'h00, 8'h00}, 1'h1},
		'{8'h10, 8'h00, 32'h0, 32'h0, 16'h0, '{8'h06, 32'h0, 8'h01, 8'h00, 8'h00}, 1'h0},
		'{8'h20, 8'h00, 32'h0, 32'h0, 16'h0, '{8'h06, 32'h0, 8'h00, 8'h00, 8'h00}, 1'h0},
		'{8'h20, 8'h00, 32'h0, 32'h0, 16'h0, '{8'h06, 32'h0, 8'hFF, 8'h00, 8'h00}, 1'h1},
		'{8'h42, 8'h00, 32'h0, 32'h0, 16'h0080, '{8'h3A, 32'h0, 8'h40, 8'h80, 8'h07}, 1'h1},
		'{8'h42, 8'h00, 32'h0, 32'h0, 16'h0080, '{8'h3A, 32'h0, 8'h40, 8'h81, 8'h07}, 1'h0},
		'{8'h82, 8'h00, 32'h0, 32'h0, 16'h0000, '{8'h3A, 32'h0, 8'h40, 8'h09, 8'h00}, 1'h1},
		'{8'h82, 8'h00, 32'h0, 32'h0, 16'h0000, '{8'h3A, 32'h0, 8'h40, 8'h09, 8'h01}, 1'h0},
		'{8'hDA, 8'h00, 32'h5, 32'hFFFF_FFFF, 16'h0580, '{8'h3A, 32'h5, 8'h00, 8'h80, 8'h05}, 1'h1},
		'{8'hDA, 8'h00, 32'h5, 32'hFFFF_FFFF, 16'h0580, '{8'h3A, 32'h5, 8'h01, 8'h80, 8'h05}, 1'h0},
		'{8'h43, 8'h00, 32'h0, 32'h0, 16'h0080, '{8'h11, 32'h0, 8'h40, 8'h81, 8'h07}, 1'h1},
		'{8'h05, 8'h00, 32'h0, 32'h0, 16'h0, '{8'h05, 32'h0, 8'h40, 8'h00, 8'h00}, 1'h0},
		'{8'h30, 8'h00, 32'h0, 32'h0, 16'h0, '{8'h06, 32'h0, 8'h00, 8'h00, 8'h00}, 1'h1}};

	// clock generation
	initial
	begin
		forever #2.5 sys_clk = ~sys_clk;
	end

	ipv6_icmp_acl_entry_matcher u_dut
	(
		.sys_clk(sys_clk), .srst(srst),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .frame_valid(frame_valid), .frame_fields(frame_fields),
		.hit_valid(hit_valid), .entry_hit(entry_hit)
	);

	frame_source u_src
	(
		.sys_clk(sys_clk),
		.frame_valid(frame_valid),
		.frame_fields(frame_fields)
	);

	// axi write: address and data offered together, response awaited
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw_done, w_done, done;
		aw_done = 0; w_done = 0; done = 0;
		@(posedge sys_clk);
		s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1'h1; s_axi_wvalid <= 1'h1; s_axi_bready <= 1'h1;
		// waits for the answer however long; only the watchdog ends a hang
		while (!done)
		begin
			@(posedge sys_clk);
			if (s_axi_bvalid)
			begin
				done = 1; s_axi_bready <= 1'h0;
				`CHK(s_axi_bresp, er, "write response")
				`CHK({aw_done, w_done}, 2'h3, "response before request taken")
			end
			if (!aw_done && s_axi_awready) begin aw_done = 1; s_axi_awvalid <= 1'h0; end
			if (!w_done && s_axi_wready) begin w_done = 1; s_axi_wvalid <= 1'h0; end
		end
	endtask : wr

	// axi read: address offered, data and response checked at rvalid
	task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic ar_done, done;
		ar_done = 0; done = 0;
		@(posedge sys_clk);
		s_axi_araddr <= a; s_axi_arvalid <= 1'h1; s_axi_rready <= 1'h1;
		// waits for the answer however long; only the watchdog ends a hang
		while (!done)
		begin
			@(posedge sys_clk);
			if (s_axi_rvalid)
			begin
				done = 1; s_axi_rready <= 1'h0;
				`CHK(s_axi_rdata, ed, "read data")
				`CHK(s_axi_rresp, er, "read response")
				`CHK(ar_done, 1'h1, "data before address taken")
			end
			if (!ar_done && s_axi_arready) begin ar_done = 1; s_axi_arvalid <= 1'h0; end
		end
	endtask : rd

	// load one entry configuration
	task automatic cfg(input row_s r);
		wr(`OFS_CTRL, {24'h0, r.ctrl}, `RESP_OKAY);
		wr(`OFS_NEXT_HDR, {24'h0, r.nh}, `RESP_OKAY);
		wr(`OFS_SRC_PATTERN, r.pat, `RESP_OKAY);
		wr(`OFS_SRC_MASK, r.mask, `RESP_OKAY);
		wr(`OFS_ICMP, {16'h0, r.icmp}, `RESP_OKAY);
	endtask : cfg

	task automatic do_reset();
		@(posedge sys_clk);
		srst <= 1'h1;
		repeat (8) @(posedge sys_clk);
		srst <= 1'h0;
	endtask : do_reset

	task automatic end_sim();
		$display("checked %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : end_sim

	// watchdog
	initial
	begin
		repeat (20000) @(posedge sys_clk);
		error_cnt++;
		$display("BAD %0t watchdog expired", $time);
		end_sim();
	end

	// main sequence
	initial
	begin
		do_reset();
		for (int i = 0; i < 28; i++)
		begin
			cfg(rows[i]);
			u_src.put(rows[i].f);
			u_src.idle();
			#1;
			`CHK(hit_valid, 1'h1, "hit_valid missing")
			`CHK(entry_hit, rows[i].hit, "entry_hit wrong")
		end
		$display("table test done");
		// second reset mid-run, reset values back
		do_reset();
		#1;
		`CHK(hit_valid, 1'h0, "hit_valid after reset")
		rd(`OFS_CTRL, 32'h0, `RESP_OKAY);
		rd(`OFS_SRC_MASK, 32'hFFFF_FFFF, `RESP_OKAY);
		rd(`OFS_FRAME_COUNT, 32'h0, `RESP_OKAY);
		$display("reset test done");
		// back-to-back frames, one hit then one miss, then counters
		wr(`OFS_NEXT_HDR, 32'h2B, `RESP_OKAY);
		wr(`OFS_CTRL, 32'h1, `RESP_OKAY);
		u_src.put('{8'h2B, 32'h0, 8'h40, 8'h00, 8'h00});
		u_src.put('{8'h2C, 32'h0, 8'h40, 8'h00, 8'h00});
		#1;
		`CHK({hit_valid, entry_hit}, 2'h3, "first of pair")
		u_src.idle();
		#1;
		`CHK({hit_valid, entry_hit}, 2'h2, "second of pair")
		@(posedge sys_clk);
		#1;
		`CHK(hit_valid, 1'h0, "hit_valid stretched")
		rd(`OFS_HIT_COUNT, 32'h1, `RESP_OKAY);
		rd(`OFS_FRAME_COUNT, 32'h2, `RESP_OKAY);
		$display("burst test done");
		// refused accesses
		wr(`OFS_HIT_COUNT, 32'h55, `RESP_SLVERR);
		rd(`OFS_HIT_COUNT, 32'h1, `RESP_OKAY);
		rd(12'h020, 32'h0, `RESP_SLVERR);
		wr(12'h020, 32'h1, `RESP_SLVERR);
		$display("error test done");
		end_sim();
	end

endmodule : ipv6_icmp_acl_entry_matcher_tb

// ==== rtl/acl_match_defines.svh ====
// register map, field positions, reset values and protocol numbers of the entry matcher
// Operation
// R1 - next header don't-care ignores the field
// R2 - specific next header must equal stored byte
// R3 - ICMP/UDP/TCP restrict protocol, enable sub-criteria
// R4 - source don't-care excludes source address
// R5 - only low 32 source address bits compared
// R6 - masked frame address equals masked pattern
// R7 - hop zero setting needs hop limit zero
// R8 - hop non-zero needs above zero; any ignores
// R9 - specific ICMP type must equal stored value
// R10 - specific ICMP code must equal stored value
// R11 - hit only when all enabled criteria match
`ifndef ACL_MATCH_DEFINES_SVH
`define ACL_MATCH_DEFINES_SVH

// register byte offsets
`define OFS_CTRL 12'h000
`define OFS_NEXT_HDR 12'h004
`define OFS_SRC_PATTERN 12'h008
`define OFS_SRC_MASK 12'h00C
`define OFS_ICMP 12'h010
`define OFS_HIT_COUNT 12'h014
`define OFS_FRAME_COUNT 12'h018

// control register fields
`define CTRL_NH_LSB 0
`define CTRL_NH_MSB 2
`define CTRL_SRC_BIT 3
`define CTRL_HOP_LSB 4
`define CTRL_HOP_MSB 5
`define CTRL_TYPE_BIT 6
`define CTRL_CODE_BIT 7
`define CTRL_WIDTH 8

// icmp register fields
`define ICMP_TYPE_LSB 0
`define ICMP_CODE_LSB 8

// reset values
`define RST_CTRL 8'h00
`define RST_NEXT_HDR 8'h00
`define RST_SRC_PATTERN 32'h0000_0000
`define RST_SRC_MASK 32'hFFFF_FFFF
`define RST_ICMP_BYTE 8'h00

// protocol numbers carried in the next header field
`define PROTO_ICMPV6 8'h3A
`define PROTO_UDP 8'h11
`define PROTO_TCP 8'h06

// bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ==== rtl/acl_match_pkg.sv ====
// types shared by the entry matcher, the frame source model and the bench
package acl_match_pkg;

	// next header criterion
	typedef enum logic [2:0]
	{
		NH_ANY = 3'b000,
		NH_SPECIFIC = 3'b001,
		NH_ICMP = 3'b010,
		NH_UDP = 3'b011,
		NH_TCP = 3'b100
	} nh_mode_e;

	// hop limit criterion
	typedef enum logic [1:0]
	{
		HOP_ANY = 2'b00,
		HOP_ZERO = 2'b01,
		HOP_NONZERO = 2'b10
	} hop_mode_e;

	// parsed header fields of one frame
	typedef struct packed
	{
		logic [7:0] next_header;
		logic [31:0] src_addr_low;
		logic [7:0] hop_limit;
		logic [7:0] icmp_type;
		logic [7:0] icmp_code;
	} frame_fields_s;

endpackage : acl_match_pkg

// ==== rtl/byte_criterion.sv ====
// one byte criterion: don't-care or exact value
`timescale 1ns/1ps
module byte_criterion
(
	input wire logic enable,
	input wire logic [7:0] stored,
	input wire logic [7:0] field,
	output logic ok
);

	// disabled criterion is always satisfied
	assign ok = !enable || (field == stored);

endmodule : byte_criterion

// ==== rtl/ipv6_icmp_acl_entry_matcher.sv ====
// access control entry matcher for IPv6 and ICMP fields, AXI4-Lite register slave
//
// Implementation choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "acl_match_defines.svh"
module ipv6_icmp_acl_entry_matcher
(
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic frame_valid,
	input wire acl_match_pkg::frame_fields_s frame_fields,
	output logic hit_valid,
	output logic entry_hit
);
	import acl_match_pkg::*;

	// merge write data into a register under byte strobes
	function automatic logic [31:0] apply_strb(input logic [31:0] old_val, input logic [31:0] data,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old_val;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
			begin
				res[i*8 +: 8] = data[i*8 +: 8];
			end
		end
		return res;
	endfunction : apply_strb

	// word-aligned offset of a byte address
	function automatic logic [11:0] word_ofs(input logic [11:0] addr);
		return {addr[11:2], 2'b00};
	endfunction : word_ofs

	// bus side state
	logic aw_held_reg;
	logic [11:0] awaddr_reg;
	logic w_held_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic bvalid_reg;
	logic [1:0] bresp_reg;
	logic rvalid_reg;
	logic [1:0] rresp_reg;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic rd_hit_next;
	logic wr_fire;
	logic [11:0] wr_ofs;
	logic wr_mapped;
	logic [31:0] ctrl_merged;
	logic [31:0] next_hdr_merged;
	logic [31:0] icmp_merged;

	// entry configuration
	logic [`CTRL_WIDTH-1:0] ctrl_reg;
	logic [7:0] next_hdr_reg;
	logic [31:0] source_address_pattern_reg;
	logic [31:0] source_address_mask_reg;
	logic [7:0] icmp_type_reg;
	logic [7:0] icmp_code_reg;
	logic [31:0] hit_count_reg;
	logic [31:0] frame_count_reg;
	logic hit_valid_reg;
	logic entry_hit_reg;

	// decoded criteria
	nh_mode_e nh_mode;
	hop_mode_e hop_mode;
	logic src_specific;
	logic type_specific;
	logic code_specific;
	logic icmp_sel;
	logic nh_ok;
	logic nh_value_ok;
	logic src_ok;
	logic hop_ok;
	logic type_ok;
	logic code_ok;
	logic all_ok;

	// handshake outputs
	assign s_axi_awready = !aw_held_reg;
	assign s_axi_wready = !w_held_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = !rvalid_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rresp = rresp_reg;
	assign s_axi_rdata = rdata_reg;
	assign hit_valid = hit_valid_reg;
	assign entry_hit = entry_hit_reg;

	// write performed once address and data are both held and the answer slot is free
	assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
	assign wr_ofs = word_ofs(awaddr_reg);
	assign wr_mapped = (wr_ofs == `OFS_CTRL) || (wr_ofs == `OFS_NEXT_HDR) ||
		(wr_ofs == `OFS_SRC_PATTERN) || (wr_ofs == `OFS_SRC_MASK) || (wr_ofs == `OFS_ICMP);

	// write address capture
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			aw_held_reg <= 1'b0;
			awaddr_reg <= 12'h000;
		end
		else if (s_axi_awvalid && s_axi_awready)
		begin
			aw_held_reg <= 1'b1;
			awaddr_reg <= s_axi_awaddr;
		end
		else if (wr_fire)
		begin
			aw_held_reg <= 1'b0;
		end
	end

	// write data capture
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			w_held_reg <= 1'b0;
			wdata_reg <= 32'h0000_0000;
			wstrb_reg <= 4'h0;
		end
		else if (s_axi_wvalid && s_axi_wready)
		begin
			w_held_reg <= 1'b1;
			wdata_reg <= s_axi_wdata;
			wstrb_reg <= s_axi_wstrb;
		end
		else if (wr_fire)
		begin
			w_held_reg <= 1'b0;
		end
	end

	// write response
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			bvalid_reg <= 1'b0;
			bresp_reg <= `RESP_OKAY;
		end
		else if (wr_fire)
		begin
			bvalid_reg <= 1'b1;
			bresp_reg <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
		end
		else if (s_axi_bready)
		begin
			bvalid_reg <= 1'b0;
		end
	end

	// strobe-merged words of the narrow registers, cut down below
	assign ctrl_merged = apply_strb({24'h000000, ctrl_reg}, wdata_reg, wstrb_reg);
	assign next_hdr_merged = apply_strb({24'h000000, next_hdr_reg}, wdata_reg, wstrb_reg);
	assign icmp_merged = apply_strb({16'h0000, icmp_code_reg, icmp_type_reg}, wdata_reg, wstrb_reg);

	// configuration registers, byte-lane writes
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			ctrl_reg <= `RST_CTRL;
			next_hdr_reg <= `RST_NEXT_HDR;
			source_address_pattern_reg <= `RST_SRC_PATTERN;
			source_address_mask_reg <= `RST_SRC_MASK;
			icmp_type_reg <= `RST_ICMP_BYTE;
			icmp_code_reg <= `RST_ICMP_BYTE;
		end
		else if (wr_fire)
		begin
			unique case (wr_ofs)
				`OFS_CTRL: ctrl_reg <= ctrl_merged[`CTRL_WIDTH-1:0];
				`OFS_NEXT_HDR: next_hdr_reg <= next_hdr_merged[7:0];
				`OFS_SRC_PATTERN: source_address_pattern_reg <= apply_strb(source_address_pattern_reg,
					wdata_reg, wstrb_reg);
				`OFS_SRC_MASK: source_address_mask_reg <= apply_strb(source_address_mask_reg,
					wdata_reg, wstrb_reg);
				`OFS_ICMP:
				begin
					icmp_type_reg <= icmp_merged[`ICMP_TYPE_LSB +: 8];
					icmp_code_reg <= icmp_merged[`ICMP_CODE_LSB +: 8];
				end
				default: ;
			endcase
		end
	end

	// read data selection
	always_comb
	begin
		rdata_next = 32'h0000_0000;
		rd_hit_next = 1'b1;
		unique case (word_ofs(s_axi_araddr))
			`OFS_CTRL: rdata_next = {24'h000000, ctrl_reg};
			`OFS_NEXT_HDR: rdata_next = {24'h000000, next_hdr_reg};
			`OFS_SRC_PATTERN: rdata_next = source_address_pattern_reg;
			`OFS_SRC_MASK: rdata_next = source_address_mask_reg;
			`OFS_ICMP: rdata_next = {16'h0000, icmp_code_reg, icmp_type_reg};
			`OFS_HIT_COUNT: rdata_next = hit_count_reg;
			`OFS_FRAME_COUNT: rdata_next = frame_count_reg;
			default: rd_hit_next = 1'b0;
		endcase
	end

	// read channel
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			rvalid_reg <= 1'b0;
			rresp_reg <= `RESP_OKAY;
			rdata_reg <= 32'h0000_0000;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			rvalid_reg <= 1'b1;
			rresp_reg <= rd_hit_next ? `RESP_OKAY : `RESP_SLVERR;
			rdata_reg <= rdata_next;
		end
		else if (s_axi_rready)
		begin
			rvalid_reg <= 1'b0;
		end
	end

	// criterion decode from the control register
	assign nh_mode = nh_mode_e'(ctrl_reg[`CTRL_NH_MSB:`CTRL_NH_LSB]);
	assign hop_mode = hop_mode_e'(ctrl_reg[`CTRL_HOP_MSB:`CTRL_HOP_LSB]);
	assign src_specific = ctrl_reg[`CTRL_SRC_BIT];
	assign type_specific = ctrl_reg[`CTRL_TYPE_BIT];
	assign code_specific = ctrl_reg[`CTRL_CODE_BIT];
	assign icmp_sel = (nh_mode == NH_ICMP); // ICMP sub-criteria live only under ICMP [R3]

	// specific next header value compare
	byte_criterion u_nh_value
	(
		.enable(1'b1),
		.stored(next_hdr_reg),
		.field(frame_fields.next_header),
		.ok(nh_value_ok)
	);

	// next header criterion
	always_comb
	begin
		unique case (ctrl_reg[`CTRL_NH_MSB:`CTRL_NH_LSB])
			NH_ANY: nh_ok = 1'b1; // field ignored [R1]
			NH_SPECIFIC: nh_ok = nh_value_ok; // [R2]
			NH_ICMP: nh_ok = (frame_fields.next_header == `PROTO_ICMPV6); // [R3]
			NH_UDP: nh_ok = (frame_fields.next_header == `PROTO_UDP); // [R3]
			NH_TCP: nh_ok = (frame_fields.next_header == `PROTO_TCP); // [R3]
			default: nh_ok = 1'b0; // reserved codes never hit
		endcase
	end

	// source address criterion on the low word only
	source_address_filter u_src
	(
		.enable(src_specific), // [R4]
		.source_address_pattern(source_address_pattern_reg),
		.source_address_mask(source_address_mask_reg), // [R6]
		.frame_addr_low(frame_fields.src_addr_low), // [R5]
		.ok(src_ok)
	);

	// hop limit criterion
	always_comb
	begin
		unique case (ctrl_reg[`CTRL_HOP_MSB:`CTRL_HOP_LSB])
			HOP_ZERO: hop_ok = (frame_fields.hop_limit == 8'h00); // [R7]
			HOP_NONZERO: hop_ok = (frame_fields.hop_limit != 8'h00); // [R8]
			default: hop_ok = 1'b1; // don't-care and reserved [R8]
		endcase
	end

	// icmp type and code criteria
	byte_criterion u_icmp_type
	(
		.enable(icmp_sel && type_specific), // [R9] [R3]
		.stored(icmp_type_reg),
		.field(frame_fields.icmp_type),
		.ok(type_ok)
	);

	byte_criterion u_icmp_code
	(
		.enable(icmp_sel && code_specific), // [R10] [R3]
		.stored(icmp_code_reg),
		.field(frame_fields.icmp_code),
		.ok(code_ok)
	);

	// every enabled criterion at once
	assign all_ok = nh_ok && src_ok && hop_ok && type_ok && code_ok; // [R11]

	// registered hit result, one cycle after the frame
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			hit_valid_reg <= 1'b0;
			entry_hit_reg <= 1'b0;
		end
		else
		begin
			hit_valid_reg <= frame_valid;
			entry_hit_reg <= frame_valid && all_ok; // [R11]
		end
	end

	// hit and frame statistics
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			hit_count_reg <= 32'h0000_0000;
			frame_count_reg <= 32'h0000_0000;
		end
		else if (frame_valid)
		begin
			frame_count_reg <= frame_count_reg + 32'h0000_0001;
			hit_count_reg <= hit_count_reg + {31'h00000000, all_ok};
		end
	end

	// next header don't-care always passes
	AST_NH_ANY_PASS: assert property (@(posedge sys_clk) disable iff (srst) // [R1]
		(nh_mode == NH_ANY) |-> nh_ok)
		else $error("next header don't-care blocked a frame");

	// specific next header mismatch gives no hit
	AST_NH_SPECIFIC: assert property (@(posedge sys_clk) disable iff (srst) // [R2]
		(frame_valid && nh_mode == NH_SPECIFIC && frame_fields.next_header != next_hdr_reg)
		|=> (hit_valid && !entry_hit))
		else $error("hit despite next header mismatch");

	// protocol selection restricts the next header to TCP, UDP or ICMPv6
	AST_PROTO_SELECT: assert property (@(posedge sys_clk) disable iff (srst) // [R3]
		(frame_valid && ((nh_mode == NH_TCP && frame_fields.next_header != `PROTO_TCP) ||
		(nh_mode == NH_UDP && frame_fields.next_header != `PROTO_UDP) ||
		(nh_mode == NH_ICMP && frame_fields.next_header != `PROTO_ICMPV6)))
		|=> !entry_hit)
		else $error("protocol selection not honoured");

	// icmp sub-criteria stay out of the decision outside ICMP mode
	AST_SUB_GATED: assert property (@(posedge sys_clk) disable iff (srst) // [R3]
		(frame_valid && !icmp_sel && nh_ok && src_ok && hop_ok) |=> entry_hit)
		else $error("icmp sub-criterion acted outside ICMP mode");

	// source don't-care ignores the address
	AST_SRC_ANY: assert property (@(posedge sys_clk) disable iff (srst) // [R4]
		!src_specific |-> src_ok)
		else $error("source don't-care blocked a frame");

	// masked source mismatch gives no hit
	AST_SRC_MASKED: assert property (@(posedge sys_clk) disable iff (srst) // [R5] [R6]
		(frame_valid && src_specific &&
		(((frame_fields.src_addr_low ^ source_address_pattern_reg) & source_address_mask_reg) != 32'h0000_0000))
		|=> !entry_hit)
		else $error("hit despite masked source mismatch");

	// hop zero setting rejects non-zero hop limits
	AST_HOP_ZERO: assert property (@(posedge sys_clk) disable iff (srst) // [R7]
		(frame_valid && hop_mode == HOP_ZERO && frame_fields.hop_limit != 8'h00) |=> !entry_hit)
		else $error("hit with hop limit above zero");

	// hop non-zero setting rejects zero hop limit
	AST_HOP_NONZERO: assert property (@(posedge sys_clk) disable iff (srst) // [R8]
		(frame_valid && hop_mode == HOP_NONZERO && frame_fields.hop_limit == 8'h00) |=> !entry_hit)
		else $error("hit with zero hop limit");

	// icmp type mismatch gives no hit
	AST_ICMP_TYPE: assert property (@(posedge sys_clk) disable iff (srst) // [R9]
		(frame_valid && icmp_sel && type_specific && frame_fields.icmp_type != icmp_type_reg) |=> !entry_hit)
		else $error("hit despite icmp type mismatch");

	// icmp code mismatch gives no hit
	AST_ICMP_CODE: assert property (@(posedge sys_clk) disable iff (srst) // [R10]
		(frame_valid && icmp_sel && code_specific && frame_fields.icmp_code != icmp_code_reg) |=> !entry_hit)
		else $error("hit despite icmp code mismatch");

	// a hit follows a frame with all criteria met, and is counted
	AST_HIT_ALL: assert property (@(posedge sys_clk) disable iff (srst) // [R11]
		entry_hit |-> ($past(frame_valid) && $past(all_ok) && hit_valid &&
		hit_count_reg == $past(hit_count_reg) + 32'h0000_0001))
		else $error("hit without every criterion matching");

endmodule : ipv6_icmp_acl_entry_matcher

// ==== rtl/source_address_filter.sv ====
// masked compare of the low source address word
`timescale 1ns/1ps
module source_address_filter
(
	input wire logic enable,
	input wire logic [31:0] source_address_pattern,
	input wire logic [31:0] source_address_mask,
	input wire logic [31:0] frame_addr_low,
	output logic ok
);

	// zero mask bits are don't-care
	assign ok = !enable ||
		((frame_addr_low & source_address_mask) == (source_address_pattern & source_address_mask));

endmodule : source_address_filter
